/* logic/dual_port_mailbox_handshake.sv */
// Notes on behaviour
// - Local read of last byte clears host write end flag.
// - Local read of byte 0 clears host write ownership.
// - With ack enabled, local read of byte 0 in host ownership drives ready low.
// - Local write of byte 0 without host ownership takes local ownership.
// - Local write of last byte sets local write end flag.
// - With ack enabled, local write of last byte drives ready low.
// - Host read of last byte clears local write end flag.
// - Host read of byte 0 clears local write ownership.
// - Host read of byte 0 sets host read end flag.
// - Host read end with its enable raises an interrupt to local CPU.
// - Host write of byte 0 without local ownership takes host ownership.
// - Host write of last byte sets host write end flag, maybe interrupts.
// - Ready returns high on host last/status read or byte 0 write; else hi-Z.
// - Control/status clears to zero on reset and standby.
//
// Design decisions made here: register access over APB and the placing of the registers.
`default_nettype none
module dual_port_mailbox_handshake
    import mailbox_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic standby,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_cs,
    input wire logic host_we,
    input wire logic [3:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic ready_n_out,
    output logic ready_n_oe_n,
    output logic host_read_end_irq,
    output logic host_write_end_irq
);
    logic [7:0] mem [MBOX_BYTES];
    logic host_write_end_flag;
    logic host_write_irq_enable;
    logic local_write_end_flag;
    logic ack_output_enable;
    logic host_read_end_flag;
    logic host_read_irq_enable;
    logic host_write_own_flag;
    logic local_write_own_flag;
    logic ready_low;
    logic [7:0] csr_value;
    logic apb_go;
    logic data_hit;
    logic csr_hit;
    logic local_lw;
    logic local_lr;
    logic local_fw;
    logic local_fr;
    logic host_lw;
    logic host_lr;
    logic host_fw;
    logic host_fr;
    logic host_csr_rd;
    logic local_mid_ok;
    logic host_mid_ok;

    mbox_access_if acc ();
    mbox_index_decode u_decode (.acc(acc));

    // Single-cycle APB: access phase always completes at once
    assign apb_go = psel && penable && clk_en;
    assign data_hit = (paddr[1:0] == 2'h0) && (paddr <= ADDR_DATA_TOP);
    assign csr_hit = (paddr == ADDR_CSR);
    assign acc.local_rd = apb_go && !pwrite && data_hit;
    assign acc.local_wr = apb_go && pwrite && data_hit;
    assign acc.local_idx = paddr[5:2];
    assign acc.host_rd = host_cs && !host_we && clk_en && host_addr != HOST_CSR_IDX;
    assign acc.host_wr = host_cs && host_we && clk_en && host_addr != HOST_CSR_IDX;
    assign acc.host_idx = host_addr;
    assign host_csr_rd = host_cs && !host_we && clk_en && host_addr == HOST_CSR_IDX;

    assign local_fw = acc.local_wr && acc.local_kind == ACC_FIRST;
    assign local_fr = acc.local_rd && acc.local_kind == ACC_FIRST;
    assign local_lw = acc.local_wr && acc.local_kind == ACC_LAST;
    assign local_lr = acc.local_rd && acc.local_kind == ACC_LAST;
    assign host_fw = acc.host_wr && acc.host_kind == ACC_FIRST;
    assign host_fr = acc.host_rd && acc.host_kind == ACC_FIRST;
    assign host_lw = acc.host_wr && acc.host_kind == ACC_LAST;
    assign host_lr = acc.host_rd && acc.host_kind == ACC_LAST;

    // Bytes 1..14 not writable by a side while the other side holds ownership
    assign local_mid_ok = !host_write_own_flag;
    assign host_mid_ok = !local_write_own_flag;

    assign csr_value = {host_write_end_flag, host_write_irq_enable, local_write_end_flag,
        ack_output_enable, host_read_end_flag, host_read_irq_enable,
        host_write_own_flag, local_write_own_flag};

    // Host write wins a same-cycle collision on one byte
    always_ff @(posedge pclk) begin
        for (int i = 0; i < MBOX_BYTES; i++) begin
            if (acc.local_wr && acc.local_idx == 4'(i)
                && (i == 0 || local_mid_ok)) begin
                mem[i] <= pwdata[7:0];
            end
            if (acc.host_wr && acc.host_idx == 4'(i) && (i == 0 || host_mid_ok)) begin
                mem[i] <= host_wdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(data_hit || csr_hit);
            if (psel && !penable && !pwrite) begin
                prdata <= 32'h0000_0000;
                if (csr_hit) begin
                    prdata[7:0] <= csr_value;
                end else if (data_hit) begin
                    prdata[7:0] <= mem[paddr[5:2]];
                end
            end
        end
    end

    // Read data captured in the cycle the host strobe is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_rdata <= 8'h00;
        end else if (clk_en && host_cs && !host_we) begin
            if (host_addr == HOST_CSR_IDX) begin
                host_rdata <= csr_value;
            end else if (host_addr <= IDX_LAST) begin
                host_rdata <= mem[host_addr];
            end else begin
                host_rdata <= 8'h00;
            end
        end
    end

    // Software-writable enables; both sides may write the ack enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_write_irq_enable <= 1'b0;
            host_read_irq_enable <= 1'b0;
            ack_output_enable <= 1'b0;
        end else if (clk_en) begin
            if (standby) begin
                host_write_irq_enable <= 1'b0;
                host_read_irq_enable <= 1'b0;
                ack_output_enable <= 1'b0;
            end else begin
                if (apb_go && pwrite && csr_hit) begin
                    host_write_irq_enable <= pwdata[BIT_HWIE];
                    host_read_irq_enable <= pwdata[BIT_HRIE];
                    ack_output_enable <= pwdata[BIT_ACKE];
                end
                if (host_cs && host_we && host_addr == HOST_CSR_IDX) begin
                    ack_output_enable <= host_wdata[BIT_ACKE];
                end
            end
        end
    end

    // Ownership: byte 0 writes claim, byte 0 reads by the peer release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_write_own_flag <= 1'b0;
            local_write_own_flag <= 1'b0;
        end else if (clk_en) begin
            if (standby) begin
                host_write_own_flag <= 1'b0;
                local_write_own_flag <= 1'b0;
            end else begin
                if (host_fw && !local_write_own_flag && !local_fw) begin
                    host_write_own_flag <= 1'b1;
                end else if (local_fr) begin
                    host_write_own_flag <= 1'b0;
                end
                if (local_fw && !host_write_own_flag) begin
                    local_write_own_flag <= 1'b1;
                end else if (host_fr) begin
                    local_write_own_flag <= 1'b0;
                end
            end
        end
    end

    // End flags: set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_write_end_flag <= 1'b0;
            local_write_end_flag <= 1'b0;
            host_read_end_flag <= 1'b0;
        end else if (clk_en) begin
            if (standby) begin
                host_write_end_flag <= 1'b0;
                local_write_end_flag <= 1'b0;
                host_read_end_flag <= 1'b0;
            end else begin
                if (host_lw && host_mid_ok) begin
                    host_write_end_flag <= 1'b1;
                end else if (local_lr) begin
                    host_write_end_flag <= 1'b0;
                end
                if (local_lw && local_mid_ok) begin
                    local_write_end_flag <= 1'b1;
                end else if (host_lr) begin
                    local_write_end_flag <= 1'b0;
                end
                if (host_fr) begin
                    host_read_end_flag <= 1'b1;
                end else if (local_fr || local_fw || host_fw) begin
                    host_read_end_flag <= 1'b0;
                end
            end
        end
    end

    // Interrupt levels follow flag and enable, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_read_end_irq <= 1'b0;
            host_write_end_irq <= 1'b0;
        end else if (clk_en) begin
            host_read_end_irq <= !standby && host_read_irq_enable
                && (host_read_end_flag || host_fr);
            host_write_end_irq <= !standby && host_write_irq_enable
                && (host_write_end_flag || (host_lw && host_mid_ok));
        end
    end

    // Ready line: low requests attention, releases win over a same-cycle pull-down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_low <= 1'b0;
        end else if (clk_en) begin
            if (standby) begin
                ready_low <= 1'b0;
            end else if (host_lr || host_csr_rd || host_fw || local_fw) begin
                ready_low <= 1'b0;
            end else if (local_fr && host_write_own_flag) begin
                ready_low <= 1'b1;
            end else if (local_lw && local_mid_ok) begin
                ready_low <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_n_out <= 1'b1;
            ready_n_oe_n <= 1'b1;
        end else if (clk_en) begin
            ready_n_out <= !ready_low;
            ready_n_oe_n <= !(ack_output_enable && !standby);
        end
    end
endmodule : dual_port_mailbox_handshake
`default_nettype wire

/* logic/mailbox_pkg.sv */
`default_nettype none
package mailbox_pkg;
    localparam int MBOX_BYTES = 15;
    localparam logic [3:0] IDX_FIRST = 4'h0;
    localparam logic [3:0] IDX_LAST = 4'hE;
    // APB byte addresses: data words 0x00..0x38, control/status at 0x40
    localparam logic [7:0] ADDR_CSR = 8'h40;
    localparam logic [7:0] ADDR_DATA_TOP = 8'h38;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam int BIT_HWEF = 7;
    localparam int BIT_HWIE = 6;
    localparam int BIT_LWEF = 5;
    localparam int BIT_ACKE = 4;
    localparam int BIT_HREF = 3;
    localparam int BIT_HRIE = 2;
    localparam int BIT_HWOF = 1;
    localparam int BIT_LWOF = 0;
    // Host port: address 0..14 data, 15 control/status
    localparam logic [3:0] HOST_CSR_IDX = 4'hF;
    typedef enum logic [1:0] {ACC_NONE, ACC_FIRST, ACC_MID, ACC_LAST} acc_kind_t;
endpackage : mailbox_pkg
`default_nettype wire

/* logic/mbox_access_if.sv */
`default_nettype none
interface mbox_access_if;
    import mailbox_pkg::*;
    logic local_rd;
    logic local_wr;
    logic [3:0] local_idx;
    logic host_rd;
    logic host_wr;
    logic [3:0] host_idx;
    acc_kind_t local_kind;
    acc_kind_t host_kind;
    modport decoder (input local_rd, local_wr, local_idx, host_rd, host_wr, host_idx,
        output local_kind, host_kind);
    modport core (output local_rd, local_wr, local_idx, host_rd, host_wr, host_idx,
        input local_kind, host_kind);
endinterface : mbox_access_if
`default_nettype wire

/* logic/mbox_index_decode.sv */
`default_nettype none
module mbox_index_decode
    import mailbox_pkg::*;
(
    mbox_access_if.decoder acc
);
    function automatic acc_kind_t classify(input logic act, input logic [3:0] idx);
        if (!act || idx > IDX_LAST) begin
            return ACC_NONE;
        end
        if (idx == IDX_FIRST) begin
            return ACC_FIRST;
        end
        if (idx == IDX_LAST) begin
            return ACC_LAST;
        end
        return ACC_MID;
    endfunction : classify

    assign acc.local_kind = classify(acc.local_rd | acc.local_wr, acc.local_idx);
    assign acc.host_kind = classify(acc.host_rd | acc.host_wr, acc.host_idx);
endmodule : mbox_index_decode
`default_nettype wire

/* tb/mbox_check_sva.sv */
`default_nettype none
module mbox_check
    import mailbox_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic standby,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic host_cs,
    input wire logic host_we,
    input wire logic [3:0] host_addr,
    input wire logic ready_n_out,
    input wire logic ready_n_oe_n,
    input wire logic host_read_end_irq,
    input wire logic host_write_end_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic unmap;
    logic lo_set;
    logic hi_set;
    logic hcfg;
    assign acc = psel && penable && clk_en;
    assign unmap = paddr[1:0] != 2'h0 || (paddr > ADDR_DATA_TOP && paddr != ADDR_CSR);
    assign lo_set = acc && (pwrite ? paddr == ADDR_DATA_TOP : paddr == 8'h00);
    // Of local writes only a byte 0 write releases ready, but any local write is accepted
    assign hi_set = (acc && pwrite) || standby
        || (host_cs && (host_we ? host_addr == IDX_FIRST : host_addr >= IDX_LAST));
    assign hcfg = acc && pwrite && paddr == ADDR_CSR;
    access_ready_a: assert property (acc |-> pready) else $error("no ready in access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    error_map_a: assert property (pready |-> pslverr == unmap) else $error("bad error");
    read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    read_irq_src_a: assert property ($rose(host_read_end_irq) |->
        $past(host_cs && !host_we && host_addr == IDX_FIRST) || $past(hcfg) || $past(hcfg, 2))
        else $error("read end irq without cause");
    write_irq_src_a: assert property ($rose(host_write_end_irq) |->
        $past(host_cs && host_we && host_addr == IDX_LAST) || $past(hcfg) || $past(hcfg, 2))
        else $error("write end irq without cause");
    ready_low_src_a: assert property ($fell(ready_n_out) |-> $past(lo_set) || $past(lo_set, 2))
        else $error("ready low without cause");
    ready_high_src_a: assert property ($rose(ready_n_out) |-> $past(hi_set) || $past(hi_set, 2))
        else $error("ready high without cause");
    standby_clear_a: assert property ((standby && clk_en) [*2] |=>
        ready_n_oe_n && !host_read_end_irq && !host_write_end_irq) else $error("standby kept state");
    cover property ($rose(host_read_end_irq));
    cover property ($fell(ready_n_out));
    cover property (pready && pslverr);
endmodule : mbox_check
bind dual_port_mailbox_handshake mbox_check i_chk (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_cs(host_cs),
    .host_we(host_we), .host_addr(host_addr), .ready_n_out(ready_n_out),
    .ready_n_oe_n(ready_n_oe_n), .host_read_end_irq(host_read_end_irq),
    .host_write_end_irq(host_write_end_irq));
`default_nettype wire

/* tb/mbox_host_model.sv */
`default_nettype none
module mbox_host_model (
    input wire logic pclk,
    output logic host_cs,
    output logic host_we,
    output logic [3:0] host_addr,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        host_cs = 1'b0;
        host_we = 1'b0;
        host_addr = 4'h0;
        host_wdata = 8'h00;
    end
    task automatic access(input logic we, input logic [3:0] a, input logic [7:0] d);
        @(posedge pclk);
        host_cs <= 1'b1;
        host_we <= we;
        host_addr <= a;
        host_wdata <= d;
        @(posedge pclk);
        host_cs <= 1'b0;
        // Released bus must not keep showing the last byte
        host_wdata <= ~d;
    endtask : access
    task automatic hwr(input logic [3:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask : hwr
    task automatic hrd(input logic [3:0] a, output logic [7:0] d);
        access(1'b0, a, 8'h00);
        @(posedge pclk);
        d = host_rdata;
    endtask : hrd
endmodule : mbox_host_model
`default_nettype wire

/* tb/dual_port_mailbox_handshake_test.sv */
`default_nettype none
module dual_port_mailbox_handshake_test;
    import mailbox_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, clk_en, standby, psel, penable, pwrite, pready, pslverr, err;
    logic host_cs, host_we, ready_n_out, ready_n_oe_n, host_read_end_irq, host_write_end_irq;
    logic [7:0] paddr, host_wdata, host_rdata, hd;
    logic [3:0] host_addr;
    logic [31:0] pwdata, prdata, rd;
    int fail_count = 0;
    int samples_checked = 0;
    dual_port_mailbox_handshake i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_cs(host_cs), .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .ready_n_out(ready_n_out), .ready_n_oe_n(ready_n_oe_n),
        .host_read_end_irq(host_read_end_irq), .host_write_end_irq(host_write_end_irq));
    mbox_host_model i_host (.pclk(pclk), .host_cs(host_cs), .host_we(host_we),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            chk(32'h0, 32'h1);
            end_sim();
        end
    endtask : apb
    task automatic csr(input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, ADDR_CSR, 32'h0);
        chk(rd & mask, exp);
    endtask : csr
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        standby = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wt(10);
        presetn <= 1'b1;
        csr(32'hFF, 32'h00);
        apb(1'b0, 8'h44, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_CSR, 32'h54);
        i_host.hwr(IDX_FIRST, 8'hA5);
        i_host.hrd(HOST_CSR_IDX, hd);
        chk({24'h0, hd} & 32'h02, 32'h02);
        apb(1'b1, 8'h14, 32'h11);
        i_host.hwr(4'h5, 8'h3C);
        i_host.hwr(IDX_LAST, 8'h7E);
        wt(2);
        chk({31'h0, host_write_end_irq}, 32'h1);
        csr(32'h80, 32'h80);
        apb(1'b0, ADDR_DATA_TOP, 32'h0);
        csr(32'h80, 32'h00);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h3C);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'hA5);
        csr(32'h02, 32'h00);
        chk({30'h0, ready_n_out, ready_n_oe_n}, 32'h0);
        $display("test host_to_local done");
        apb(1'b1, 8'h00, 32'h61);
        csr(32'h01, 32'h01);
        chk({31'h0, ready_n_out}, 32'h1);
        i_host.hwr(4'h3, 8'hEE);
        apb(1'b1, 8'h0C, 32'h42);
        apb(1'b1, ADDR_DATA_TOP, 32'h99);
        csr(32'h20, 32'h20);
        chk({31'h0, ready_n_out}, 32'h0);
        i_host.hrd(IDX_LAST, hd);
        chk({24'h0, hd}, 32'h99);
        csr(32'h21, 32'h01);
        chk({31'h0, ready_n_out}, 32'h1);
        i_host.hrd(4'h3, hd);
        chk({24'h0, hd}, 32'h42);
        i_host.hrd(IDX_FIRST, hd);
        chk({24'h0, hd}, 32'h61);
        wt(2);
        chk({31'h0, host_read_end_irq}, 32'h1);
        csr(32'h09, 32'h08);
        $display("test local_to_host done");
        @(posedge pclk);
        standby <= 1'b1;
        wt(3);
        standby <= 1'b0;
        csr(32'hFF, 32'h00);
        chk({31'h0, ready_n_oe_n}, 32'h1);
        $display("test standby done");
        // Host claim while frozen must leave ownership untouched
        clk_en <= 1'b0;
        i_host.hwr(IDX_FIRST, 8'h5A);
        clk_en <= 1'b1;
        csr(32'h02, 32'h00);
        i_host.hwr(HOST_CSR_IDX, 8'h10);
        wt(2);
        chk({31'h0, ready_n_oe_n}, 32'h0);
        csr(32'h10, 32'h10);
        $display("test freeze_and_host_ack done");
        end_sim();
    end
endmodule : dual_port_mailbox_handshake_test
`default_nettype wire
